/* File: include/adc_seq_consts.vh */
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// ----------------------------------------------------------------------
// clocking and time
// ----------------------------------------------------------------------
`define MCLK_NS           4
`define SYSCLK_NS         1000
`define SYSCLK_CYC        (`SYSCLK_NS / `MCLK_NS)
`define CONV_US           20
`define CYCLE_US          40
`define EXTRA_SAMPLE_SYS  12
`define FILT_RISES        2'd2

// ----------------------------------------------------------------------
// converter and serial frame
// ----------------------------------------------------------------------
`define SAR_BITS          8
`define TICKS_PER_BIT     ((`CONV_US * 1000) / (`SYSCLK_NS * `SAR_BITS))
`define ADDR_BITS         4
`define ADDR_EDGES        4'd4
`define SAMPLE_EDGE       4'd3
`define LAST_EDGE         4'd7
`define XFER_EDGES        4'd8
`define SELFTEST_ADDR     4'hb
`define SELFTEST_CODE     8'h80
`define RESULT_RESET      8'h00
`define SAR_FIRST_TRIAL   8'h80

`endif

/* File: core/pin_sync.v */
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module pin_sync #(
	parameter W = 4
) (
	input  wire         mclk_i,
	input  wire         rst_n_i,
	input  wire [W-1:0] pin_i,
	output wire [W-1:0] lvl_o,
	output wire [W-1:0] rise_o,
	output wire [W-1:0] fall_o
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	reg [W-1:0] prev_q;

	// --------------------------------------------------------------------
	// two-flop synchroniser, third flop only for edge finding
	// --------------------------------------------------------------------
	// pins idle high so the select line starts deasserted
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= {W{1'b1}};
			sync_q <= {W{1'b1}};
			prev_q <= {W{1'b1}};
		end else begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// edges compare the second and third flops, never the first
	assign lvl_o  = sync_q;
	assign rise_o = sync_q & ~prev_q;
	assign fall_o = ~sync_q & prev_q;

endmodule // pin_sync

/* File: core/sar_engine.v */
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module sar_engine #(
	parameter W   = `SAR_BITS,
	parameter TPB = `TICKS_PER_BIT
) (
	input  wire         mclk_i,
	input  wire         rst_n_i,
	input  wire         start_i,
	input  wire         abort_i,
	input  wire         tick_i,
	input  wire         cmp_i,
	input  wire         selftest_i,
	output reg  [W-1:0] trial_o,
	output reg  [W-1:0] code_o,
	output reg          done_o
);

	reg [2:0] bit_q;
	reg [3:0] ph_q;
	reg       run_q;
	reg [W-1:0] acc_q;
	reg       keep;
	reg [W-1:0] acc_d;

	// set one weight bit on top of the bits already decided
	function [W-1:0] set_bit;
		input [W-1:0] v;
		input [2:0]   b;
		begin
			set_bit = v | ({{(W-1){1'b0}}, 1'b1} << b);
		end
	endfunction

	// --------------------------------------------------------------------
	// decision for the current weight
	// --------------------------------------------------------------------
	// self-test compares against the internal mid-scale level
	always @* begin
		keep  = selftest_i ? (`SELFTEST_CODE >= trial_o) : cmp_i;
		acc_d = keep ? trial_o : acc_q;
	end

	// --------------------------------------------------------------------
	// one weight per TPB system ticks, first tick lets the dac settle
	// --------------------------------------------------------------------
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_q   <= 3'd0;
			ph_q    <= 4'd0;
			run_q   <= 1'b0;
			acc_q   <= {W{1'b0}};
			trial_o <= {W{1'b0}};
			code_o  <= `RESULT_RESET;
			done_o  <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (abort_i) begin
				run_q <= 1'b0;
			end else if (start_i) begin
				run_q   <= 1'b1;
				bit_q   <= W[2:0] - 3'd1;
				ph_q    <= 4'd0;
				acc_q   <= {W{1'b0}};
				trial_o <= set_bit({W{1'b0}}, W[2:0] - 3'd1);
			end else if (run_q && tick_i) begin
				if (ph_q == TPB[3:0] - 4'd1) begin
					ph_q  <= 4'd0;
					acc_q <= acc_d;
					if (bit_q == 3'd0) begin
						run_q   <= 1'b0;
						code_o  <= acc_d;
						trial_o <= acc_d;
						done_o  <= 1'b1;
					end else begin
						bit_q   <= bit_q - 3'd1;
						trial_o <= set_bit(acc_d, bit_q - 3'd1);
					end
				end else begin
					ph_q <= ph_q + 4'd1;
				end
			end
		end
	end

endmodule // sar_engine

/* File: core/serial_adc_control_sequencer.v */
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

// Function
// - select high: output released, transfer clock and address ignored.
// - select low recognized after two system rises then one system fall.
// - on recognition, previous result msb appears with no clock edge.
// - first four transfer clock rises capture 4-bit address, msb first.
// - first four transfer clock falls shift out result bits two to five.
// - sampling of the new channel starts after the fourth fall.
// - falls five to seven shift out result bits six, seven, eight.
// - eighth fall starts 12 system clock extra sampling, output released.
// - conversion follows, done within 20 us; cycle repeats every 40 us.
// - recognized select fall during conversion resets and aborts it.
// - new full sequence before conversion ends aborts it; old result out.
// - end-of-conversion goes low on the eighth transfer clock fall.
// - end-of-conversion goes high when the result is ready.
// - address 1011 converts internal self-test level near mid-scale.
// - above high reference gives all ones, below low gives all zeros.
// - any of eleven inputs or self-test, in any order.
// - output released on select rise or eighth transfer clock fall.

module serial_adc_control_sequencer #(
	parameter SYS_DIV = `SYSCLK_CYC,
	parameter DIV_W   = 8,
	parameter W       = `SAR_BITS
) (
	input  wire         mclk_i,
	input  wire         rst_n_i,
	input  wire         sel_n_i,
	input  wire         xfer_clk_i,
	input  wire         addr_i,
	input  wire         cmp_i,
	output reg          dout_o,
	output reg          dout_oe_n_o,
	output reg          eoc_o,
	output reg  [3:0]   chan_o,
	output reg          sample_o,
	output wire [W-1:0] dac_o,
	output reg          sel_ok_o,
	output reg          conv_busy_o
);

	// conversion phases
	// idle doubles as the state left behind by any abort
	localparam C_IDLE = 2'b00;
	localparam C_SAMP = 2'b01;
	localparam C_CONV = 2'b10;

	// --------------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------------
	wire [3:0]       s_lvl;
	wire [3:0]       s_rise;
	wire [3:0]       s_fall;
	wire             sel_hi;
	wire             xrise;
	wire             xfall;
	wire             addr_bit;
	wire             cmp_bit;
	reg  [DIV_W-1:0] div_q;
	wire             sys_rise;
	wire             sys_fall;
	reg  [1:0]       frise_q;
	wire             sel_set;
	reg  [3:0]       xcnt_q;
	reg  [3:0]       addr_sh_q;
	reg  [W-1:0]     sh_q;
	reg  [W-1:0]     result_q;
	reg  [1:0]       cst_q;
	reg  [3:0]       scnt_q;
	wire             io_rise;
	wire             io_fall;
	wire             new_seq;
	wire             samp_done;
	wire             sar_abort;
	wire [W-1:0]     sar_code;
	wire             sar_done;
	wire             take_result;

	// --------------------------------------------------------------------
	// shared decode
	// --------------------------------------------------------------------
	// recognized and still low: the only state in which the pins count
	function live;
		input ok;
		input hi;
		begin
			live = ok && !hi;
		end
	endfunction

	// --------------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------------
	// all four pins share one delay, so address stays aligned with clock
	// and a metastable pin level never reaches more than one flop
	pin_sync #(
		.W (4)
	) u_sync (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.pin_i   ({cmp_i, addr_i, xfer_clk_i, sel_n_i}),
		.lvl_o   (s_lvl),
		.rise_o  (s_rise),
		.fall_o  (s_fall)
	);

	assign sel_hi   = s_lvl[0];
	assign xrise    = s_rise[1];
	assign xfall    = s_fall[1];
	assign addr_bit = s_lvl[2];
	assign cmp_bit  = s_lvl[3];

	// --------------------------------------------------------------------
	// internal system clock, about 1 us
	// --------------------------------------------------------------------
	// free running; its phase is not tied to select, so recognition
	// takes anywhere between one and a half and two and a half system periods
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_q <= {DIV_W{1'b0}};
		end else if (div_q == SYS_DIV[DIV_W-1:0] - 1'b1) begin
			div_q <= {DIV_W{1'b0}};
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	assign sys_rise = (div_q == {DIV_W{1'b0}});
	assign sys_fall = (div_q == SYS_DIV[DIV_W:1]);

	// --------------------------------------------------------------------
	// select noise filter
	// --------------------------------------------------------------------
	// a low glitch shorter than the filter never reaches the sequencer
	// counting restarts whenever the synced level goes high again
	assign sel_set = !sel_ok_o && !sel_hi && sys_fall &&
		(frise_q == `FILT_RISES);

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frise_q  <= 2'd0;
			sel_ok_o <= 1'b0;
		end else if (sel_hi) begin
			frise_q  <= 2'd0;
			sel_ok_o <= 1'b0;
		end else if (sel_set) begin
			sel_ok_o <= 1'b1;
		end else if (!sel_ok_o && sys_rise &&
			frise_q != `FILT_RISES) begin
			frise_q <= frise_q + 2'd1;
		end
	end

	// --------------------------------------------------------------------
	// qualified transfer clock events
	// --------------------------------------------------------------------
	// edges count only once select is recognized and still low
	assign io_rise   = xrise && live(sel_ok_o, sel_hi);
	assign io_fall   = xfall && live(sel_ok_o, sel_hi);
	assign new_seq   = io_rise && (xcnt_q == `XFER_EDGES);
	assign samp_done = (cst_q == C_SAMP) && sys_rise &&
		(scnt_q == `EXTRA_SAMPLE_SYS - 1);
	// leaving the conversion early must also stop the engine
	assign sar_abort = (sel_set || new_seq) && (cst_q != C_IDLE);

	// an abort in the same cycle as done keeps the old result, so a cut
	// conversion never overwrites what the host reads next
	assign take_result = sar_done && !sar_abort;

	// --------------------------------------------------------------------
	// successive approximation engine
	// --------------------------------------------------------------------
	// trial level drives the dac pins directly; cmp_bit answers it
	sar_engine #(
		.W   (W),
		.TPB (`TICKS_PER_BIT)
	) u_sar (
		.mclk_i     (mclk_i),
		.rst_n_i    (rst_n_i),
		.start_i    (samp_done),
		.abort_i    (sar_abort),
		.tick_i     (sys_rise),
		.cmp_i      (cmp_bit),
		.selftest_i (chan_o == `SELFTEST_ADDR),
		.trial_o    (dac_o),
		.code_o     (sar_code),
		.done_o     (sar_done)
	);

	// --------------------------------------------------------------------
	// frame and conversion sequencer
	// --------------------------------------------------------------------
	// conversion runs on whatever select does; later transfer events
	// in the same cycle override it, so an abort always wins
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			xcnt_q      <= `XFER_EDGES;
			addr_sh_q   <= 4'h0;
			sh_q        <= `RESULT_RESET;
			result_q    <= `RESULT_RESET;
			dout_o      <= 1'b0;
			dout_oe_n_o <= 1'b1;
			eoc_o       <= 1'b1;
			chan_o      <= 4'h0;
			sample_o    <= 1'b0;
			cst_q       <= C_IDLE;
			scnt_q      <= 4'd0;
			conv_busy_o <= 1'b0;
		end else begin
			// conversion progress, independent of select (host keeps it
			// high or the clock low meanwhile)
			case (cst_q)
			// counts system rises only; transfer clock plays no part here
			C_SAMP: begin
				if (sys_rise) begin
					scnt_q <= scnt_q + 4'd1;
				end
				if (samp_done) begin
					cst_q    <= C_CONV;
					sample_o <= 1'b0;
				end
			end
			C_CONV: begin
				// a same-cycle abort is handled by the frame logic below
				if (take_result) begin
					result_q    <= sar_code;
					eoc_o       <= 1'b1;
					cst_q       <= C_IDLE;
					conv_busy_o <= 1'b0;
					// select held low across conversions: show msb
					if (live(sel_ok_o, sel_hi)) begin
						sh_q        <= sar_code;
						dout_o      <= sar_code[W-1];
						dout_oe_n_o <= 1'b0;
						xcnt_q      <= 4'd0;
					end
				end
			end
			default: begin
				scnt_q <= 4'd0;
			end
			endcase

			// serial frame
			// select handling first, then transfer edges in order
			if (sel_hi) begin
				// a frame cut by select rise is dropped; conversion goes on
				dout_oe_n_o <= 1'b1;
				if (xcnt_q != `XFER_EDGES) begin
					xcnt_q <= `XFER_EDGES;
				end
			end else if (sel_set) begin
				sh_q        <= result_q;
				dout_o      <= result_q[W-1];
				dout_oe_n_o <= 1'b0;
				xcnt_q      <= 4'd0;
				if (cst_q != C_IDLE) begin
					cst_q       <= C_IDLE;
					sample_o    <= 1'b0;
					eoc_o       <= 1'b1;
					conv_busy_o <= 1'b0;
				end
			end else if (new_seq) begin
				// restart mid-conversion: old result goes out again
				cst_q       <= C_IDLE;
				sample_o    <= 1'b0;
				conv_busy_o <= 1'b0;
				sh_q        <= result_q;
				dout_o      <= result_q[W-1];
				dout_oe_n_o <= 1'b0;
				xcnt_q      <= 4'd0;
				addr_sh_q   <= {addr_sh_q[2:0], addr_bit};
			end else if (io_rise && xcnt_q < `ADDR_EDGES) begin
				addr_sh_q <= {addr_sh_q[2:0], addr_bit};
			end else if (io_fall && xcnt_q < `XFER_EDGES) begin
				// each fall moves the next result bit out
				xcnt_q <= xcnt_q + 4'd1;
				sh_q   <= {sh_q[W-2:0], 1'b0};
				dout_o <= sh_q[W-2];
				if (xcnt_q == `SAMPLE_EDGE) begin
					// any code is taken, reserved ones included
					chan_o   <= addr_sh_q;
					sample_o <= 1'b1;
				end
				if (xcnt_q == `LAST_EDGE) begin
					dout_oe_n_o <= 1'b1;
					eoc_o       <= 1'b0;
					cst_q       <= C_SAMP;
					scnt_q      <= 4'd0;
					conv_busy_o <= 1'b1;
				end
			end
		end
	end

endmodule // serial_adc_control_sequencer

/* File: tb/adc_seq_assertions.sv */
`timescale 1ns/1ps
module adc_seq_assertions #(
	parameter SYS_DIV = 8,
	parameter W       = 8
) (
	input wire         mclk_i,
	input wire         rst_n_i,
	input wire         sel_n_i,
	input wire         xfer_clk_i,
	input wire         addr_i,
	input wire         cmp_i,
	input wire         dout_o,
	input wire         dout_oe_n_o,
	input wire         eoc_o,
	input wire [3:0]   chan_o,
	input wire         sample_o,
	input wire [W-1:0] dac_o,
	input wire         sel_ok_o,
	input wire         conv_busy_o
);
	// ------------------------------------------------------------------
	// select low run length
	// ------------------------------------------------------------------
	reg [9:0] low_q;
	// saturating, so one long select-low stretch cannot wrap and refire
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			low_q <= 10'h000;
		else if (sel_n_i)
			low_q <= 10'h000;
		else if (low_q != 10'h3ff)
			low_q <= low_q + 10'h001;
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	oe_off_sel_a: assert property (sel_n_i [*4] |-> dout_oe_n_o)
		else $error("data driven while select high");
	ok_off_sel_a: assert property (sel_n_i [*4] |-> !sel_ok_o)
		else $error("select seen while high");
	filter_min_a: assert property ($rose(sel_ok_o) |->
		low_q >= 3 * SYS_DIV / 2)
		else $error("select recognized too early");
	filter_max_a: assert property (low_q == 3 * SYS_DIV + 8 |->
		sel_ok_o)
		else $error("select recognized too late");
	oe_on_ok_a: assert property ($fell(dout_oe_n_o) |-> sel_ok_o)
		else $error("data driven without recognition");
	eoc_fall_a: assert property ($fell(eoc_o) |->
		dout_oe_n_o && conv_busy_o)
		else $error("end flag fell without release");
	extra_samp_a: assert property ($fell(eoc_o) |-> sample_o [*8])
		else $error("extra sampling cut short");
	eoc_bound_a: assert property ($fell(eoc_o) |-> ##[1:900] eoc_o)
		else $error("conversion never ended");
	eoc_idle_a: assert property ($rose(eoc_o) |-> !conv_busy_o)
		else $error("end flag up while busy");
	chan_hold_a: assert property ($changed(chan_o) |->
		sample_o && sel_ok_o)
		else $error("channel changed outside frame");
	dac_busy_a: assert property ($changed(dac_o) |-> conv_busy_o)
		else $error("trial level moved outside conversion");

	cover property ($rose(eoc_o));
	cover property ($rose(sample_o));
	cover property ($fell(sel_ok_o) && conv_busy_o);
endmodule // adc_seq_assertions

/* File: tb/adc_host_model.sv */
`timescale 1ns/1ps
module adc_host_model (
	input  wire mclk_i,
	input  wire dline_i,
	input  wire sel_ok_i,
	output reg  sel_n_o,
	output reg  xfer_clk_o,
	output reg  addr_o
);
	// idle: deselected, transfer clock parked low
	initial begin
		sel_n_o = 1'b1;
		xfer_clk_o = 1'b0;
		addr_o = 1'b0;
	end

	// select level change just after an edge
	task sel(input v);
		begin
			@(posedge mclk_i);
			sel_n_o <= v;
		end
	endtask

	// one 8-pulse frame at 80 ns; bit k read before rise k
	task frame(input [3:0] a, output [7:0] d);
		integer i;
		integer k;
		begin
			k = 0;
			// no clocking until recognized; bounded for the deselected case
			while (sel_ok_i !== 1'b1 && k < 200) begin
				@(posedge mclk_i);
				k = k + 1;
			end
			for (i = 0; i < 8; i = i + 1) begin
				repeat (9) @(posedge mclk_i);
				d[7-i] = dline_i;
				addr_o <= (i < 4) ? a[3-i] : ~addr_o;
				@(posedge mclk_i);
				xfer_clk_o <= 1'b1;
				repeat (10) @(posedge mclk_i);
				xfer_clk_o <= 1'b0;
			end
			addr_o <= ~addr_o;
		end
	endtask
endmodule // adc_host_model

/* File: tb/serial_adc_control_sequencer_tb_top.sv */
`timescale 1ns/1ps
module serial_adc_control_sequencer_tb_top;
	reg        mclk_i;
	reg        rst_n_i = 1'b0;
	reg        cmp_i;
	reg  [7:0] vin = 8'h00;
	wire       sel_n, xfer_clk, addr, dout, oe_n, eoc, sample, ok, busy;
	wire [3:0] chan;
	wire [7:0] dac;
	wire       dline;
	reg  [7:0] d;
	integer    bad_count = 0;
	integer    samples_checked = 0;
	integer    cyc = 0;

	// released data line shows the inverse, so a read of it never matches
	assign dline = oe_n ? ~dout : dout;

	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	// comparator: input at or above trial level
	always @(posedge mclk_i) begin
		cmp_i <= (vin >= dac);
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count = bad_count + 1;
			give_verdict;
		end
	end

	serial_adc_control_sequencer #(.SYS_DIV(8)) DUT (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n),
		.xfer_clk_i(xfer_clk), .addr_i(addr), .cmp_i(cmp_i),
		.dout_o(dout), .dout_oe_n_o(oe_n), .eoc_o(eoc), .chan_o(chan),
		.sample_o(sample), .dac_o(dac), .sel_ok_o(ok),
		.conv_busy_o(busy));

	adc_host_model host (.mclk_i(mclk_i), .dline_i(dline),
		.sel_ok_i(ok), .sel_n_o(sel_n), .xfer_clk_o(xfer_clk),
		.addr_o(addr));

	task check(input [7:0] got, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				$display("wrong value at %0t: got %h exp %h", $time, got, exp);
				bad_count = bad_count + 1;
			end
		end
	endtask

	task wait_eoc;
		integer k;
		begin
			k = 0;
			while (eoc !== 1'b1 && k < 900) begin
				@(posedge mclk_i);
				k = k + 1;
			end
		end
	endtask

	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", samples_checked, bad_count);
			if (bad_count == 0 && samples_checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task t_idle;
		begin
			check({oe_n, eoc, ok, sample, chan}, 8'hc0);
			host.frame(4'h5, d);
			check({oe_n, eoc, ok, sample, chan}, 8'hc0);
			$display("test idle done");
		end
	endtask

	// full frame, conversion, new msb while still selected, release
	task conv(input [3:0] a, input [7:0] v, input [7:0] prev,
		input [7:0] code);
		begin
			vin = v;
			host.sel(1'b0);
			host.frame(a, d);
			check(d, prev);
			check(chan, a);
			repeat (8) @(posedge mclk_i);
			check({sample, eoc, oe_n, busy}, 8'h0b);
			wait_eoc;
			@(posedge mclk_i);
			check({sample, eoc, dline}, {6'h00, 1'b1, code[7]});
			check(dac, code);
			host.sel(1'b1);
			repeat (6) @(posedge mclk_i);
			check(oe_n, 8'h01);
		end
	endtask

	task t_codes;
		begin
			conv(4'h3, 8'h5a, 8'h00, 8'h5a);
			conv(4'h0, 8'hff, 8'h5a, 8'hff);
			conv(4'hb, 8'h00, 8'hff, 8'h80);
			conv(4'hc, 8'h00, 8'h80, 8'h00);
			conv(4'h9, 8'h00, 8'h00, 8'h00);
			$display("test codes done");
		end
	endtask

	// select bounce during extra sampling, then a frame restart during extra sampling
	task t_aborts;
		begin
			vin = 8'h33;
			host.sel(1'b0);
			host.frame(4'h2, d);
			repeat (20) @(posedge mclk_i);
			host.sel(1'b1);
			repeat (4) @(posedge mclk_i);
			host.sel(1'b0);
			repeat (60) @(posedge mclk_i);
			check({eoc, busy}, 8'h02);
			host.frame(4'h2, d);
			check(d, 8'h00);
			host.frame(4'h1, d);
			check(d[6:0], 7'h00);
			check(chan, 4'h1);
			wait_eoc;
			host.sel(1'b1);
			repeat (6) @(posedge mclk_i);
			conv(4'h5, 8'h00, 8'h33, 8'h00);
			$display("test aborts done");
		end
	endtask

	initial begin
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		t_idle;
		t_codes;
		t_aborts;
		give_verdict;
	end
endmodule // serial_adc_control_sequencer_tb_top

bind serial_adc_control_sequencer adc_seq_assertions #(
	.SYS_DIV(SYS_DIV), .W(W)) u_chk (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n_i),
	.xfer_clk_i(xfer_clk_i), .addr_i(addr_i), .cmp_i(cmp_i),
	.dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .eoc_o(eoc_o),
	.chan_o(chan_o), .sample_o(sample_o), .dac_o(dac_o),
	.sel_ok_o(sel_ok_o), .conv_busy_o(conv_busy_o));
